// ===== hdl/valve_drive_regs.vh
// register map, field positions, reset values and timing for the
// valve drive function logic; definitions only
`ifndef VALVE_DRIVE_REGS_VH
`define VALVE_DRIVE_REGS_VH

// byte addresses of the 32-bit registers
`define VD_CTRL_ADDR      8'h00
`define VD_FORCE_ADDR     8'h04
`define VD_PURGE_ADDR     8'h08
`define VD_CURVE_A_ADDR   8'h0C
`define VD_CURVE_B_ADDR   8'h10
`define VD_STATUS_ADDR    8'h14

// control register fields
`define VD_BLOCK_EN       0
`define VD_BLOCK_POL      1
`define VD_FORCE_EN       2
`define VD_FORCE_POL      3
`define VD_STAT_EN        4
`define VD_STAT_BYTE      5
`define VD_STAT_MODE_LO   6
`define VD_STAT_BITVAL    8
`define VD_PURGE_EN       9
`define VD_PSTAT_EN       10
`define VD_PSTAT_MODE_LO  11
`define VD_AUTO_PURGE     13
`define VD_CURVE_EN       14
`define VD_PAIR3_EN       15
`define VD_PAIR4_EN       16
`define VD_NORM_OPEN      17
`define VD_CTRL_BITS      18
`define VD_CTRL_RESET     18'h00142

// purge register fields
`define VD_PURGE_DUR_LO   0
`define VD_PURGE_WEEKS_LO 8
`define VD_PURGE_THR_LO   16

// reset values
`define VD_FORCE_RESET    7'h1E
`define VD_DUR_RESET      8'h0A
`define VD_WEEKS_RESET    4'h6
`define VD_THR_RESET      7'h63
`define VD_CURVE_A_RESET  32'h64640000
`define VD_CURVE_B_RESET  32'h32323232

// send policies
`define VD_SEND_NONE      2'h0
`define VD_SEND_CHANGE    2'h1
`define VD_SEND_REQUEST   2'h2
`define VD_SEND_BOTH      2'h3

// percent and time figures
`define VD_FULL_PCT       7'h64
`define VD_MIN_PER_WEEK   10080

`endif

// ===== hdl/valve_drive_function_logic.v
// valve drive function logic: block, forced operation, position status,
// purge with weekly cycle, characteristic curve correction.
// assumes telegram strobes and the minute tick come from logic on clk_sys;
// a later stage turns the drive percentage into a pwm output.
//
// The register offsets and the Wishbone slave port are this design's own decisions.

`include "valve_drive_regs.vh"

module valve_drive_function_logic #(
    parameter MIN_PER_WEEK = `VD_MIN_PER_WEEK
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        reset,
    // wishbone slave
    input  wire        wbCyc,
    input  wire        wbStb,
    input  wire        wbWe,
    input  wire [7:0]  wbAdr,
    input  wire [3:0]  wbSel,
    input  wire [31:0] wbDatIn,
    output reg  [31:0] wbDatOut,
    output reg         wbAck,
    // bus telegrams, bus voltage and minute tick
    input  wire        ctrlValid,
    input  wire [6:0]  ctrlValue,
    input  wire        blockValid,
    input  wire        blockObj,
    input  wire        forceValid,
    input  wire        forceObj,
    input  wire        purgeTrigger,
    input  wire        statusRequest,
    input  wire        purgeStatusRequest,
    input  wire        busVoltageOk,
    input  wire        minuteTick,
    // status objects
    output reg         statusSend,
    output reg  [7:0]  statusValue,
    output reg         purgeStatusSend,
    output reg         purgeStatusValue,
    // valve output stage
    output reg  [6:0]  valvePosition,
    output reg  [6:0]  driveLevel
);

localparam [16:0] WEEK_MIN = MIN_PER_WEEK[16:0];

reg  [`VD_CTRL_BITS-1:0] ctrl_reg;
reg  [6:0]  forcePos_reg;
reg  [7:0]  purgeDur_reg;
reg  [3:0]  purgeWeeks_reg;
reg  [6:0]  purgeThr_reg;
reg  [31:0] curveA_reg;
reg  [31:0] curveB_reg;
reg  [6:0]  ctrlVal_reg;
reg  [6:0]  savedCtrl_reg;
reg         blockObj_reg;
reg         forceObj_reg;
reg         purgeActive_reg;
reg         purgePending_reg;
reg  [7:0]  purgeLeft_reg;
reg  [16:0] cycleMin_reg;
reg  [7:0]  lastStatus_reg;
reg         lastPurgeStat_reg;
reg         statusValid_reg;
reg         voltMeta_reg;
reg         voltOk_reg;

// bus voltage sense comes from the supply monitor, not from clk_sys logic
always @(posedge clk_sys) begin
    if (reset) begin
        voltMeta_reg <= 1'b0;
        voltOk_reg   <= 1'b0;
    end else begin
        voltMeta_reg <= busVoltageOk;
        voltOk_reg   <= voltMeta_reg;
    end
end

wire [1:0] statMode  = ctrl_reg[`VD_STAT_MODE_LO+1:`VD_STAT_MODE_LO];
wire [1:0] pstatMode = ctrl_reg[`VD_PSTAT_MODE_LO+1:`VD_PSTAT_MODE_LO];
wire busWrite = wbCyc & wbStb & wbWe & wbAck;
wire purgeReg = wbAdr == `VD_PURGE_ADDR;

// block and force decisions
wire blocked = ctrl_reg[`VD_BLOCK_EN] &
               (blockObj_reg == ctrl_reg[`VD_BLOCK_POL]);
wire forced  = ctrl_reg[`VD_FORCE_EN] &
               (forceObj_reg == ctrl_reg[`VD_FORCE_POL]);
wire prioActive = blocked | forced;

// control value fed to the curve
reg [6:0] curveIn;
always @* begin
    if (forced) begin
        curveIn = forcePos_reg;
    end else if (purgeActive_reg) begin
        curveIn = `VD_FULL_PCT;
    end else begin
        curveIn = ctrlVal_reg;
    end
end

// characteristic curve: search of the enabled pairs around the input
// the nearest pair at or below the input is the low end
reg  [27:0] pairCv;
reg  [27:0] pairPos;
reg  [3:0]  pairOn;
reg         hasLo;
reg         hasHi;
reg  [6:0]  loCv;
reg  [6:0]  loPos;
reg  [6:0]  hiCv;
reg  [6:0]  hiPos;
reg  signed [15:0] span;
reg  signed [15:0] prod;
reg  signed [15:0] quot;
reg  [6:0]  curveOut;
integer i;
always @* begin
    pairCv  = {curveB_reg[22:16], curveB_reg[6:0],
               curveA_reg[22:16], curveA_reg[6:0]};
    pairPos = {curveB_reg[30:24], curveB_reg[14:8],
               curveA_reg[30:24], curveA_reg[14:8]};
    pairOn  = {ctrl_reg[`VD_PAIR4_EN], ctrl_reg[`VD_PAIR3_EN], 2'h3};
    hasLo = 1'b0;
    hasHi = 1'b0;
    loCv  = 7'h00;
    loPos = 7'h00;
    hiCv  = 7'h00;
    hiPos = 7'h00;
    for (i = 0; i < 4; i = i + 1) begin
        if (pairOn[i]) begin
            if (pairCv[i*7 +: 7] <= curveIn) begin
                if (!hasLo || pairCv[i*7 +: 7] > loCv ||
                    (pairCv[i*7 +: 7] == loCv &&
                     pairPos[i*7 +: 7] > loPos)) begin
                    hasLo = 1'b1;
                    loCv  = pairCv[i*7 +: 7];
                    loPos = pairPos[i*7 +: 7];
                end
            end else if (!hasHi || pairCv[i*7 +: 7] < hiCv ||
                         (pairCv[i*7 +: 7] == hiCv &&
                          pairPos[i*7 +: 7] > hiPos)) begin
                hasHi = 1'b1;
                hiCv  = pairCv[i*7 +: 7];
                hiPos = pairPos[i*7 +: 7];
            end
        end
    end
    span = $signed({9'h000, hiCv}) - $signed({9'h000, loCv});
    prod = ($signed({9'h000, curveIn}) - $signed({9'h000, loCv})) *
           ($signed({9'h000, hiPos}) - $signed({9'h000, loPos}));
    quot = 16'sh0000;
    if (!ctrl_reg[`VD_CURVE_EN]) begin
        curveOut = curveIn;
    end else if (!hasLo) begin
        curveOut = hiPos;
    end else if (!hasHi) begin
        curveOut = loPos;
    end else begin
        quot = prod / span;
        curveOut = loPos + quot[6:0];
    end
end

// position status object value
reg [7:0] statusNow;
always @* begin
    if (ctrl_reg[`VD_STAT_BYTE]) begin
        statusNow = {1'b0, valvePosition};
    end else if (valvePosition != 7'h00) begin
        statusNow = {7'h00, ctrl_reg[`VD_STAT_BITVAL]};
    end else begin
        statusNow = {7'h00, ~ctrl_reg[`VD_STAT_BITVAL]};
    end
end

// purge start, end and cycle decisions
wire cycleDone = ctrl_reg[`VD_AUTO_PURGE] &&
                 cycleMin_reg >= purgeWeeks_reg * WEEK_MIN;
wire purgeStart = ctrl_reg[`VD_PURGE_EN] && !purgeActive_reg &&
                  (purgeTrigger || cycleDone);
// timers stand still while the bus is unpowered
wire purgeExpire = purgeActive_reg && minuteTick && voltOk_reg &&
                   purgeLeft_reg <= 8'h01;
wire purgeSkip = purgeActive_reg && prioActive &&
                 ctrlVal_reg == `VD_FULL_PCT;
wire purgeEnd = purgeExpire || purgeSkip;

// register bus
always @(posedge clk_sys) begin
    if (reset) begin
        wbAck        <= 1'b0;
        wbDatOut     <= 32'h00000000;
        ctrl_reg     <= `VD_CTRL_RESET;
        forcePos_reg <= `VD_FORCE_RESET;
        purgeDur_reg <= `VD_DUR_RESET;
        purgeWeeks_reg <= `VD_WEEKS_RESET;
        purgeThr_reg <= `VD_THR_RESET;
        curveA_reg   <= `VD_CURVE_A_RESET;
        curveB_reg   <= `VD_CURVE_B_RESET;
    end else begin
        wbAck <= wbCyc & wbStb & ~wbAck;
        if (wbCyc & wbStb & ~wbAck) begin
            if (wbAdr == `VD_CTRL_ADDR) begin
                wbDatOut <= {14'h0000, ctrl_reg};
            end else if (wbAdr == `VD_FORCE_ADDR) begin
                wbDatOut <= {25'h0000000, forcePos_reg};
            end else if (purgeReg) begin
                wbDatOut <= {9'h000, purgeThr_reg, 4'h0,
                             purgeWeeks_reg, purgeDur_reg};
            end else if (wbAdr == `VD_CURVE_A_ADDR) begin
                wbDatOut <= curveA_reg;
            end else if (wbAdr == `VD_CURVE_B_ADDR) begin
                wbDatOut <= curveB_reg;
            end else if (wbAdr == `VD_STATUS_ADDR) begin
                wbDatOut <= {cycleMin_reg[10:0], purgeActive_reg,
                             forced, blocked, valvePosition,
                             ctrlVal_reg, purgeLeft_reg[3:0]};
            end else begin
                wbDatOut <= 32'h00000000;
            end
        end
        if (busWrite) begin
            if (wbAdr == `VD_CTRL_ADDR) begin
                if (wbSel[0]) ctrl_reg[7:0]   <= wbDatIn[7:0];
                if (wbSel[1]) ctrl_reg[15:8]  <= wbDatIn[15:8];
                if (wbSel[2]) ctrl_reg[17:16] <= wbDatIn[17:16];
            end else if (wbAdr == `VD_FORCE_ADDR) begin
                if (wbSel[0] && wbDatIn[6:0] <= `VD_FULL_PCT)
                    forcePos_reg <= wbDatIn[6:0];
            end else if (purgeReg) begin
                if (wbSel[0] && wbDatIn[7:0] != 8'h00)
                    purgeDur_reg <= wbDatIn[7:0];
                if (wbSel[1] && wbDatIn[11:8] != 4'h0 &&
                    wbDatIn[11:8] <= 4'hC)
                    purgeWeeks_reg <= wbDatIn[11:8];
                if (wbSel[2] && wbDatIn[22:16] != 7'h00 &&
                    wbDatIn[22:16] < `VD_FULL_PCT)
                    purgeThr_reg <= wbDatIn[22:16];
            end else if (wbAdr == `VD_CURVE_A_ADDR) begin
                if (wbSel[0]) curveA_reg[7:0]   <= wbDatIn[7:0];
                if (wbSel[1]) curveA_reg[15:8]  <= wbDatIn[15:8];
                if (wbSel[2]) curveA_reg[23:16] <= wbDatIn[23:16];
                if (wbSel[3]) curveA_reg[31:24] <= wbDatIn[31:24];
            end else if (wbAdr == `VD_CURVE_B_ADDR) begin
                if (wbSel[0]) curveB_reg[7:0]   <= wbDatIn[7:0];
                if (wbSel[1]) curveB_reg[15:8]  <= wbDatIn[15:8];
                if (wbSel[2]) curveB_reg[23:16] <= wbDatIn[23:16];
                if (wbSel[3]) curveB_reg[31:24] <= wbDatIn[31:24];
            end
        end
    end
end

// objects, purge sequence and cycle timer
always @(posedge clk_sys) begin
    if (reset) begin
        ctrlVal_reg      <= 7'h00;
        savedCtrl_reg    <= 7'h00;
        blockObj_reg     <= 1'b0;
        forceObj_reg     <= 1'b0;
        purgeActive_reg  <= 1'b0;
        purgePending_reg <= 1'b0;
        purgeLeft_reg    <= 8'h00;
        cycleMin_reg     <= 17'h00000;
    end else begin
        if (blockValid) blockObj_reg <= blockObj;
        if (forceValid) forceObj_reg <= forceObj;
        // telegrams during a purge are kept for the restore
        if (ctrlValid && purgeActive_reg && !purgeEnd) begin
            savedCtrl_reg <= ctrlValue;
        end else if (ctrlValid) begin
            ctrlVal_reg <= ctrlValue;
        end
        if (purgeStart) begin
            purgeActive_reg  <= 1'b1;
            purgePending_reg <= 1'b0;
            purgeLeft_reg    <= purgeDur_reg;
            savedCtrl_reg    <= ctrlValid ? ctrlValue : ctrlVal_reg;
        end else if (purgeEnd) begin
            purgeActive_reg  <= 1'b0;
            purgePending_reg <= 1'b0;
            purgeLeft_reg    <= 8'h00;
            ctrlVal_reg      <= ctrlValid ? ctrlValue : savedCtrl_reg;
        end else if (purgeActive_reg) begin
            if (minuteTick && voltOk_reg)
                purgeLeft_reg <= purgeLeft_reg - 8'h01;
            if (prioActive) begin
                purgePending_reg <= 1'b1;
            end else if (purgePending_reg) begin
                purgePending_reg <= 1'b0;
                purgeLeft_reg    <= purgeDur_reg;
            end
        end
        if (busWrite && purgeReg) begin
            cycleMin_reg <= 17'h00000;
        end else if (purgeEnd && !purgeSkip) begin
            cycleMin_reg <= 17'h00000;
        end else if (purgeEnd || cycleDone || (ctrlValid &&
                     ctrlValue >= purgeThr_reg)) begin
            cycleMin_reg <= 17'h00000;
        end else if (ctrl_reg[`VD_AUTO_PURGE] && minuteTick &&
                     voltOk_reg && !purgeActive_reg) begin
            cycleMin_reg <= cycleMin_reg + 17'h00001;
        end
    end
end

// valve output stage and status objects
always @(posedge clk_sys) begin
    if (reset) begin
        valvePosition     <= 7'h00;
        driveLevel        <= 7'h00;
        statusSend        <= 1'b0;
        statusValue       <= 8'h00;
        purgeStatusSend   <= 1'b0;
        purgeStatusValue  <= 1'b0;
        lastStatus_reg    <= 8'h00;
        lastPurgeStat_reg <= 1'b0;
        statusValid_reg   <= 1'b0;
    end else begin
        // blocking freezes the valve where it stands
        if (!blocked) begin
            valvePosition <= curveOut;
        end
        if (ctrl_reg[`VD_NORM_OPEN]) begin
            driveLevel <= `VD_FULL_PCT - valvePosition;
        end else begin
            driveLevel <= valvePosition;
        end
        statusValid_reg <= 1'b1;
        statusValue     <= statusNow;
        lastStatus_reg  <= statusNow;
        statusSend <= ctrl_reg[`VD_STAT_EN] && statusValid_reg &&
            ((ctrlValid && statMode != `VD_SEND_NONE) ||
             (statMode[0] && statusNow != lastStatus_reg) ||
             (statMode[1] && statusRequest));
        purgeStatusValue  <= purgeActive_reg;
        lastPurgeStat_reg <= purgeActive_reg;
        purgeStatusSend <= ctrl_reg[`VD_PURGE_EN] &&
            ctrl_reg[`VD_PSTAT_EN] &&
            ((ctrlValid && pstatMode != `VD_SEND_NONE) ||
             (pstatMode[0] && purgeActive_reg != lastPurgeStat_reg) ||
             (pstatMode[1] && purgeStatusRequest));
    end
end

endmodule

// ===== bench/valve_drive_checker_assertions.sv
// concurrent checks on the valve drive function logic ports
// bound from the bench top; assumes full-word writes of the control word
module valve_drive_checker (
    // clock and reset
    input logic        clk_sys,
    input logic        reset,
    // wishbone
    input logic        wbCyc,
    input logic        wbStb,
    input logic        wbWe,
    input logic [7:0]  wbAdr,
    input logic [3:0]  wbSel,
    input logic [31:0] wbDatIn,
    input logic [31:0] wbDatOut,
    input logic        wbAck,
    // telegrams and outputs
    input logic        ctrlValid,
    input logic        statusSend,
    input logic [6:0]  valvePosition,
    input logic [6:0]  driveLevel
);
    logic [2:0] stat_reg;
    logic       modeNone;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    // shadow of status enable and send policy, updated when the write lands
    always @(posedge clk_sys) begin
        if (reset)
            stat_reg <= 3'h1;
        else if (wbCyc && wbStb && wbAck && wbWe && wbAdr == 8'h00 && wbSel[0])
            stat_reg <= {wbDatIn[4], wbDatIn[7:6]};
    end
    assign modeNone = !stat_reg[2] || stat_reg[1:0] == 2'h0;

    chk_ack_pulse: assert property (wbAck |=> !wbAck)
        else $error("ack longer than one cycle");
    chk_ack_answer: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
        else $error("ack not one cycle after request");
    chk_ack_cause: assert property (wbAck |-> $past(wbCyc && wbStb))
        else $error("ack without request");
    chk_unmapped_zero: assert property (
        wbAck && !wbWe && wbAdr > 8'h14 |-> wbDatOut == 32'h0)
        else $error("unmapped read not zero");
    chk_pos_range: assert property (valvePosition <= 7'h64)
        else $error("valve position above full");
    chk_drive_type: assert property (
        !$past(reset) |-> driveLevel == $past(valvePosition) ||
        driveLevel == 7'h64 - $past(valvePosition))
        else $error("drive level unrelated to position");
    chk_send_ctrl: assert property (ctrlValid && !modeNone |=> statusSend)
        else $error("no status send after control value");
    chk_send_none: assert property (
        modeNone && $past(modeNone) |-> !statusSend)
        else $error("status sent while update only");
endmodule

// ===== bench/telegram_source.sv
// model of the bus devices that send telegrams to the valve channel
// one telegram per send call; object lines scramble outside telegrams
module telegram_source #(
    parameter TICK_CYC = 20
) (
    // clock
    input  logic       clk_sys,
    // telegrams
    output logic       ctrlValid,
    output logic [6:0] ctrlValue,
    output logic       blockValid,
    output logic       blockObj,
    output logic       forceValid,
    output logic       forceObj,
    output logic       purgeTrigger,
    output logic       statusRequest,
    output logic       purgeStatusRequest,
    // time base
    output logic       busVoltageOk,
    output logic       minuteTick
);
    int         kind;
    int         tickCnt = 0;
    logic [6:0] val;
    logic       go = 1'b0;

    logic       voltOk = 1'b1;

    assign busVoltageOk = voltOk;
    initial {ctrlValid, ctrlValue, blockValid, blockObj, forceValid, forceObj,
        purgeTrigger, statusRequest, purgeStatusRequest, minuteTick} = '0;

    always @(posedge clk_sys) begin
        ctrlValid <= go && kind == 0;
        blockValid <= go && kind == 1;
        forceValid <= go && kind == 2;
        purgeTrigger <= go && kind == 3;
        statusRequest <= go && kind == 4;
        purgeStatusRequest <= go && kind == 5;
        ctrlValue <= (go && kind == 0) ? val : ~ctrlValue;
        blockObj <= (go && kind == 1) ? val[0] : ~blockObj;
        forceObj <= (go && kind == 2) ? val[0] : ~forceObj;
        go <= 1'b0;
        tickCnt <= (tickCnt == TICK_CYC - 1) ? 0 : tickCnt + 1;
        minuteTick <= tickCnt == 0;
    end

    task automatic send(input int k, input logic [6:0] v);
        @(negedge clk_sys);
        kind = k;
        val = v;
        go = 1'b1;
        @(posedge clk_sys);
    endtask

    task automatic set_volt(input logic v);
        @(posedge clk_sys);
        voltOk <= v;
    endtask
endmodule

// ===== bench/tb_valve_drive_function_logic.sv
// self-checking bench for the valve drive function logic
// status sends are queued as expectations and compared by a monitor
module tb_valve_drive_function_logic;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, reset, wbCyc, wbStb, wbWe, wbAck;
    logic [7:0]  wbAdr, statusValue, e;
    logic [3:0]  wbSel;
    logic [31:0] wbDatIn, wbDatOut, rd;
    logic        ctrlValid, blockValid, blockObj, forceValid, forceObj;
    logic        purgeTrigger, statusRequest, purgeStatusRequest;
    logic        busVoltageOk, minuteTick, statusSend, purgeStatusSend;
    logic        purgeStatusValue;
    logic [6:0]  ctrlValue, valvePosition, driveLevel, last, p;
    logic [7:0]  expQ[$];
    int          mismatches = 0, checks_done = 0, c;
    int          tbl[7] = '{10, 20, 35, 50, 90, 95, 100};

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    valve_drive_function_logic #(.MIN_PER_WEEK(2)) uut (.clk_sys, .reset,
        .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatIn, .wbDatOut, .wbAck,
        .ctrlValid, .ctrlValue, .blockValid, .blockObj, .forceValid,
        .forceObj, .purgeTrigger, .statusRequest, .purgeStatusRequest,
        .busVoltageOk, .minuteTick, .statusSend, .statusValue,
        .purgeStatusSend, .purgeStatusValue, .valvePosition, .driveLevel);
    telegram_source #(.TICK_CYC(20)) partner (.clk_sys, .ctrlValid,
        .ctrlValue, .blockValid, .blockObj, .forceValid, .forceObj,
        .purgeTrigger, .statusRequest, .purgeStatusRequest, .busVoltageOk,
        .minuteTick);

    task check(input string what, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, ex, got);
        end
    endtask

    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatIn <= d;
        do @(posedge clk_sys); while (wbAck !== 1'b1);
        rd = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    // sorted curve: 20/30, 50/40, 90/80 (20/10 loses to 20/30)
    function logic [6:0] curve(input int v);
        if (v <= 20) return 7'd30;
        if (v >= 90) return 7'd80;
        if (v >= 50) return 7'(v - 10);
        return 7'(30 + (v - 20) / 3);
    endfunction

    task ctrl(input int v);
        expQ.push_back({1'b0, last});
        partner.send(0, 7'(v));
        last = curve(v);
    endtask

    task ask;
        repeat (2) @(posedge clk_sys);
        expQ.push_back({1'b0, last});
        partner.send(4, 7'h0);
    endtask

    always @(posedge clk_sys) begin
        if (statusSend === 1'b1) begin
            if (expQ.size() == 0) check("status send", 0, 1);
            else begin
                e = expQ.pop_front();
                if (e !== 8'hFF) check("statusValue", e, statusValue);
            end
        end
    end

    task give_verdict;
        check("pending sends", 0, expQ.size());
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        give_verdict;
    end

    initial begin
        {reset, wbCyc, wbStb, wbWe, wbAdr, wbDatIn} = {1'b1, 43'h0};
        wbSel = 4'hF;
        void'($urandom(78));
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        wb(0, 8'h04, 0);
        check("force reset", 32'h1E, rd & 32'h7F);
        wb(0, 8'h08, 0);
        check("purge reset", 32'h0063060A, rd & 32'h007F0FFF);
        wb(0, 8'h0C, 0);
        check("pair 1/2 reset", 32'h64640000, rd & 32'h7F7F7F7F);
        wb(0, 8'h10, 0);
        check("pair 3/4 reset", 32'h32323232, rd);
        wb(0, 8'h40, 0);
        check("unmapped", 0, rd);
        wb(1, 8'h0C, 32'h0A14505A);
        wb(1, 8'h10, 32'h28321E14);
        wb(1, 8'h04, 32'd50);
        wb(1, 8'h08, 32'h00630101);
        // release the block object before blocking is enabled
        partner.send(1, 7'h1);
        wb(1, 8'h00, 32'h0001C7BD);
        wb(0, 8'h00, 0);
        check("control word", 32'h1C7BD, rd & 32'h3FFFF);
        expQ.push_back(8'hFF);
        partner.send(0, 7'h0);
        last = 7'd30;
        ask;
        for (int i = 0; i < 11; i++) begin
            c = (i < 7) ? tbl[i] : 50 + $urandom % 41;
            ctrl(c);
            ask;
        end
        partner.send(2, 7'h1);
        repeat (3) @(posedge clk_sys);
        check("forced position", 40, valvePosition);
        partner.send(2, 7'h0);
        repeat (3) @(posedge clk_sys);
        check("force released", last, valvePosition);
        p = last;
        partner.send(1, 7'h0);
        repeat (3) @(posedge clk_sys);
        ctrl(35);
        repeat (3) @(posedge clk_sys);
        check("blocked", p, valvePosition);
        partner.send(1, 7'h1);
        repeat (3) @(posedge clk_sys);
        check("block released", 35, valvePosition);
        partner.send(3, 7'h1);
        repeat (3) @(posedge clk_sys);
        check("purge position", 80, valvePosition);
        check("purge status", 1, purgeStatusValue);
        repeat (60) @(posedge clk_sys);
        check("after purge", 35, valvePosition);
        check("purge ended", 0, purgeStatusValue);
        wb(1, 8'h00, 32'h0003C7BD);
        repeat (3) @(posedge clk_sys);
        check("drive level", 65, driveLevel);
        wb(1, 8'h00, 32'h0003C73D);
        partner.send(0, 7'd50);
        repeat (5) @(posedge clk_sys);
        partner.set_volt(1'b0);
        wb(1, 8'h00, 32'h0003EF3D);
        wb(1, 8'h08, 32'h00630101);
        repeat (100) @(posedge clk_sys);
        check("purge while bus down", 0, purgeStatusValue);
        partner.set_volt(1'b1);
        c = 0;
        while (purgeStatusValue !== 1'b1 && c < 80) begin
            @(posedge clk_sys);
            c++;
        end
        check("automatic purge", 1, purgeStatusValue);
        check("purge status send", 1, purgeStatusSend);
        give_verdict;
    end
endmodule

bind valve_drive_function_logic valve_drive_checker chk (.clk_sys, .reset,
    .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatIn, .wbDatOut, .wbAck,
    .ctrlValid, .statusSend, .valvePosition, .driveLevel);
